// File: hw/omcc_pkg.sv
// Package with constants and types of the operating mode clock control.
package omcc_pkg;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [31:0] OMCC_ADDR_CTRL = 32'h0000_0000;
   localparam logic [31:0] OMCC_ADDR_STAT = 32'h0000_0004;
   localparam logic [7:0] OMCC_CTRL_RESET = 8'h03;
   localparam int OMCC_DIV_MSB = 7;
   localparam int OMCC_DIV_LSB = 5;
   localparam int OMCC_FAST_BIT = 4;
   localparam int OMCC_LRDY_BIT = 3;
   localparam int OMCC_HRDY_BIT = 2;
   localparam int OMCC_IDLE_BIT = 1;
   localparam int OMCC_HLSEL_BIT = 0;
   localparam logic [7:0] OMCC_WR_MASK = 8'hF3;
   localparam logic [2:0] OMCC_DIV_FIRST_HS = 3'h2;

   // ****************************************************************
   // Oscillator settle counts, in oscillator cycles
   // ****************************************************************
   localparam logic [10:0] OMCC_XTAL_SETTLE = 11'h400;
   localparam logic [10:0] OMCC_HRC_SETTLE = 11'h010;
   localparam logic [10:0] OMCC_LRC_SETTLE = 11'h002;

   // ****************************************************************
   // Source selections and states
   // ****************************************************************
   localparam logic [1:0] OMCC_HS_CRYSTAL = 2'h0;
   localparam logic [1:0] OMCC_HS_EXT_RC = 2'h1;
   localparam logic [1:0] OMCC_HS_INT_RC = 2'h2;

   localparam logic [1:0] OMCC_SRC_HIGH = 2'h0;
   localparam logic [1:0] OMCC_SRC_DIV = 2'h1;
   localparam logic [1:0] OMCC_SRC_LOW = 2'h2;
   localparam logic [1:0] OMCC_SRC_SUB = 2'h3;

   typedef enum logic [5:0] {
      OMCC_ST_RUN = 6'h01,
      OMCC_ST_IDLE_CLOCK_STOPPED_MODE = 6'h02,
      OMCC_ST_IDLE_CLOCK_KEPT_MODE = 6'h04,
      OMCC_ST_DEEPEST_POWER_DOWN_MODE = 6'h08,
      OMCC_ST_LIGHT_POWER_DOWN_MODE = 6'h10,
      OMCC_ST_WAKE = 6'h20
   } omcc_state_t;

   // Configuration options and enables that come from other blocks.
   typedef struct packed {
      logic [1:0] hs_source;
      logic ls_is_crystal;
      logic watchdog_enable;
      logic watchdog_from_sub;
      logic low_voltage_detector_enable;
      logic system_clock_keep_in_idle;
   } omcc_cfg_t;

   // Clock gating view towards the CPU and the peripherals.
   typedef struct packed {
      logic cpu_run;
      logic high_speed_osc_on;
      logic low_speed_osc_on;
      logic substitute_clock_on;
      logic watchdog_clock_on;
      logic time_base_clock_on;
      logic watchdog_disable;
   } omcc_gate_t;

endpackage

// File: hw/omcc_top.sv
// Operating mode and system clock controller with its AHB-Lite register.
`timescale 1ns/100ps
//
// Summary of operation
// [R1] Two run modes and four CPU-off modes are provided.
// [R2] Full-speed run clocks from the high-speed oscillator divided 1 to 64.
// [R3] Low-speed run uses the low-speed clock; high-speed oscillator stopped.
// [R4] Halt with idle enable low enters a sleep mode.
// [R5] Deepest sleep stops CPU, substitute and watchdog clocks; watchdog off.
// [R6] Deepest sleep refused while the low-voltage detector is enabled.
// [R7] Light sleep keeps substitute and watchdog clocks when detector or WDT needs.
// [R8] Halt with idle enable high enters idle; keep bit picks which.
// [R9] Idle with clock stopped halts the system oscillator and the CPU; the low-speed oscillator runs on there as substitute clock.
// [R10] In that idle, watchdog clock runs only from the substitute clock.
// [R11] Idle with clock kept keeps the oscillator; watchdog clock on.
// [R12] One 8-bit control register with the six documented fields.
// [R13] Divider codes 000/001 low speed, 010..111 high speed /64../2.
// [R14] High/low select 1 gives undivided high-speed clock.
// [R15] Switching to the low-speed clock turns the high-speed oscillator off.
// [R16] Fast wake-up runs from the substitute clock, crystal systems only.
// [R17] Low-speed ready clears in deepest sleep; sets after 1024 or 2 cycles.
// [R18] High-speed ready clears when stopped; sets after 1024 or 16 cycles.
// [R19] Fast wake-up switches to the crystal once its ready flag sets.
// [R20] Software writes to both ready flags are ignored.
// [R21] The control register resets to 03h.
//
module omcc_top (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic high_speed_osc_i,
   input wire logic low_speed_osc_i,
   input wire omcc_pkg::omcc_cfg_t cfg_i,
   input wire logic halt_i,
   input wire logic wakeup_i,
   output omcc_pkg::omcc_gate_t gate_o,
   output logic system_clock_en_o,
   output logic [1:0] system_clock_src_o,
   output omcc_pkg::omcc_state_t mode_o,
   output logic deep_sleep_refused_o
);
   import omcc_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // Divide mask for the divided high-speed codes: 010 gives /64.
   function automatic logic [5:0] div_mask(input logic [2:0] code);
      logic [2:0] shift;
      shift = 3'(code - OMCC_DIV_FIRST_HS);
      div_mask = 6'(6'h3F >> shift);
   endfunction

   // Three-stage capture; a rise counts once the last two agree.
   function automatic logic agreed_rise(input logic s2, input logic s3,
                                        input logic stable);
      agreed_rise = (s2 == s3) && s3 && !stable;
   endfunction

   // ****************************************************************
   // Oscillator input capture
   // ****************************************************************
   logic [2:0] hs_sync_r;
   logic [2:0] ls_sync_r;
   logic hs_stable_r;
   logic ls_stable_r;
   wire hs_rise = agreed_rise(hs_sync_r[1], hs_sync_r[2], hs_stable_r);
   wire ls_rise = agreed_rise(ls_sync_r[1], ls_sync_r[2], ls_stable_r);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hs_sync_r <= 3'h0;
         ls_sync_r <= 3'h0;
         hs_stable_r <= 1'b0;
         ls_stable_r <= 1'b0;
      end else begin
         hs_sync_r <= {hs_sync_r[1:0], high_speed_osc_i};
         ls_sync_r <= {ls_sync_r[1:0], low_speed_osc_i};
         if (hs_sync_r[1] == hs_sync_r[2]) begin
            hs_stable_r <= hs_sync_r[2];
         end
         if (ls_sync_r[1] == ls_sync_r[2]) begin
            ls_stable_r <= ls_sync_r[2];
         end
      end
   end

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   logic [7:0] ctrl_r;
   logic hs_ready_r;
   logic ls_ready_r;
   omcc_state_t state_r;
   omcc_state_t state_nxt;
   logic fast_active_r;
   logic fast_active_nxt;

   wire [2:0] div_sel = ctrl_r[OMCC_DIV_MSB:OMCC_DIV_LSB];
   wire fast_en = ctrl_r[OMCC_FAST_BIT];
   wire idle_en = ctrl_r[OMCC_IDLE_BIT];
   wire hl_sel = ctrl_r[OMCC_HLSEL_BIT];
   // [R14] Undivided select.
   // [R13] Divider decode.
   wire sel_low = !hl_sel && (div_sel < OMCC_DIV_FIRST_HS);
   wire sel_div = !hl_sel && !sel_low;
   wire hs_is_crystal = (cfg_i.hs_source == OMCC_HS_CRYSTAL);
   wire [7:0] ctrl_view = {ctrl_r[7:4], ls_ready_r, hs_ready_r,
                           ctrl_r[1:0]};

   // ****************************************************************
   // Mode sequencer
   // ****************************************************************
   wire in_run = (state_r == OMCC_ST_RUN);
   wire in_deepest_power_down_mode = (state_r == OMCC_ST_DEEPEST_POWER_DOWN_MODE);
   wire in_light_power_down_mode = (state_r == OMCC_ST_LIGHT_POWER_DOWN_MODE);
   wire in_idle_clock_stopped_mode = (state_r == OMCC_ST_IDLE_CLOCK_STOPPED_MODE);
   wire in_idle_clock_kept_mode = (state_r == OMCC_ST_IDLE_CLOCK_KEPT_MODE);
   wire halt_take = halt_i && in_run && !fast_active_r;
   // [R6] Deep sleep refusal.
   wire deep_allowed = !cfg_i.low_voltage_detector_enable &&
                       !cfg_i.watchdog_enable;
   wire refuse_deep = halt_take && !idle_en &&
                      cfg_i.low_voltage_detector_enable;
   wire needed_ready = sel_low ? ls_ready_r : hs_ready_r;
   // [R16] Fast wake-up only for a crystal, from light sleep or stopped idle.
   wire fast_ok = fast_en && hs_is_crystal && !sel_low &&
                  (in_light_power_down_mode || in_idle_clock_stopped_mode);

   always_comb begin
      state_nxt = state_r;
      fast_active_nxt = fast_active_r;
      case (state_r)
         OMCC_ST_RUN: begin
            if (halt_take) begin
               if (idle_en) begin
                  // [R8] Idle choice.
                  state_nxt = cfg_i.system_clock_keep_in_idle ?
                              OMCC_ST_IDLE_CLOCK_KEPT_MODE : OMCC_ST_IDLE_CLOCK_STOPPED_MODE;
               end else begin
                  // [R4] Sleep choice.
                  state_nxt = deep_allowed ? OMCC_ST_DEEPEST_POWER_DOWN_MODE :
                              OMCC_ST_LIGHT_POWER_DOWN_MODE;
               end
            end
            // [R19] Switch to crystal.
            if (fast_active_r && hs_ready_r) begin
               fast_active_nxt = 1'b0;
            end
         end
         OMCC_ST_IDLE_CLOCK_KEPT_MODE: begin
            if (wakeup_i) begin
               state_nxt = OMCC_ST_RUN;
            end
         end
         OMCC_ST_IDLE_CLOCK_STOPPED_MODE, OMCC_ST_DEEPEST_POWER_DOWN_MODE, OMCC_ST_LIGHT_POWER_DOWN_MODE: begin
            if (wakeup_i) begin
               if (fast_ok) begin
                  state_nxt = OMCC_ST_RUN;
                  fast_active_nxt = 1'b1;
               end else begin
                  state_nxt = OMCC_ST_WAKE;
               end
            end
         end
         OMCC_ST_WAKE: begin
            if (needed_ready) begin
               state_nxt = OMCC_ST_RUN;
            end
         end
         default: begin
            state_nxt = OMCC_ST_RUN;
            fast_active_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= OMCC_ST_WAKE;
         fast_active_r <= 1'b0;
      end else begin
         // [R1] Six modes.
         state_r <= state_nxt;
         fast_active_r <= fast_active_nxt;
      end
   end

   // ****************************************************************
   // Oscillator and clock gating
   // ****************************************************************
   // [R7] Light sleep keeps the substitute clock only when it is needed.
   wire sub_needed = cfg_i.low_voltage_detector_enable ||
                     (cfg_i.watchdog_enable && cfg_i.watchdog_from_sub);
   // [R5] Deepest sleep stops all slow clocks.
   wire sub_on = !in_deepest_power_down_mode && (!in_light_power_down_mode || sub_needed);
   // [R10] Watchdog clock in idle with clock stopped.
   // [R11] Watchdog clock in idle with clock kept.
   wire wdt_clk_on = in_deepest_power_down_mode ? 1'b0 :
                     in_light_power_down_mode ? sub_needed :
                     in_idle_clock_stopped_mode ? cfg_i.watchdog_from_sub : 1'b1;
   // [R9] High-speed oscillator stopped in idle_clock_stopped_mode and both sleeps.
   wire osc_stopped = in_idle_clock_stopped_mode || in_deepest_power_down_mode || in_light_power_down_mode;
   // [R15] Low-speed selection turns the high-speed oscillator off.
   // [R3] High-speed clock stopped in low-speed run.
   wire hs_osc_on = !osc_stopped && !sel_low;
   wire ls_osc_on = sub_on || (!osc_stopped && sel_low);

   // ****************************************************************
   // Ready flags
   // ****************************************************************
   logic [10:0] hs_cnt_r;
   logic [10:0] ls_cnt_r;
   wire [10:0] hs_settle = hs_is_crystal ? OMCC_XTAL_SETTLE :
                           OMCC_HRC_SETTLE;
   wire [10:0] ls_settle = cfg_i.ls_is_crystal ? OMCC_XTAL_SETTLE :
                           OMCC_LRC_SETTLE;

   // The counts run on captured oscillator edges, so a stopped or
   // missing oscillator leaves its flag low rather than faking ready.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hs_cnt_r <= 11'h000;
         hs_ready_r <= 1'b0;
      end else if (!hs_osc_on) begin
         // [R18] Cleared while stopped.
         hs_cnt_r <= 11'h000;
         hs_ready_r <= 1'b0;
      end else if (hs_rise && !hs_ready_r) begin
         hs_cnt_r <= 11'(hs_cnt_r + 11'h001);
         // [R18] Set after settle count.
         if (11'(hs_cnt_r + 11'h001) >= hs_settle) begin
            hs_ready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ls_cnt_r <= 11'h000;
         ls_ready_r <= 1'b0;
      end else if (!ls_osc_on) begin
         // [R17] Cleared while stopped.
         ls_cnt_r <= 11'h000;
         ls_ready_r <= 1'b0;
      end else if (ls_rise && !ls_ready_r) begin
         ls_cnt_r <= 11'(ls_cnt_r + 11'h001);
         // [R17] Set after settle count.
         if (11'(ls_cnt_r + 11'h001) >= ls_settle) begin
            ls_ready_r <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // System clock enable
   // ****************************************************************
   logic [5:0] div_cnt_r;
   logic sys_en_r;
   logic [1:0] src_r;
   wire [5:0] mask = div_mask(div_sel);
   wire div_tick = hs_rise && ((div_cnt_r & mask) == mask);
   wire clk_running = in_run || in_idle_clock_kept_mode;
   // [R2] Source pick for full-speed, divided and low-speed run.
   wire [1:0] src_pick = fast_active_r ? OMCC_SRC_SUB :
                         hl_sel ? OMCC_SRC_HIGH :
                         sel_low ? OMCC_SRC_LOW : OMCC_SRC_DIV;
   wire sys_tick = (src_pick == OMCC_SRC_HIGH) ? hs_rise :
                   (src_pick == OMCC_SRC_DIV) ? div_tick : ls_rise;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt_r <= 6'h00;
         sys_en_r <= 1'b0;
         src_r <= OMCC_SRC_HIGH;
      end else begin
         if (hs_rise) begin
            div_cnt_r <= 6'(div_cnt_r + 6'h01);
         end
         sys_en_r <= clk_running && sys_tick;
         src_r <= src_pick;
      end
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   logic wr_pend_r;
   logic [31:0] addr_r;
   logic [31:0] rdata_r;
   wire take = hsel_i && htrans_i[1] && hready_i;
   wire hit_ctrl = (addr_r == OMCC_ADDR_CTRL);
   wire rd_ctrl = (haddr_i == OMCC_ADDR_CTRL);
   wire rd_stat = (haddr_i == OMCC_ADDR_STAT);
   wire [31:0] rd_mux = rd_ctrl ? {24'h000000, ctrl_view} :
                        rd_stat ? {26'h0000000, state_r} : 32'h0;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pend_r <= 1'b0;
         addr_r <= 32'h0;
      end else begin
         wr_pend_r <= take && hwrite_i;
         if (take) begin
            addr_r <= haddr_i;
         end
      end
   end

   // Read data is captured at the edge that takes the address phase.
   // A flag change during the data phase is seen by the next read.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0;
      end else if (take && !hwrite_i) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= 32'h0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // [R21] Reset value.
         ctrl_r <= OMCC_CTRL_RESET;
      end else if (wr_pend_r && hit_ctrl) begin
         // [R12] Field layout.
         // [R20] Ready flags masked.
         ctrl_r <= (hwdata_i[7:0] & OMCC_WR_MASK) |
                   (ctrl_r & ~OMCC_WR_MASK);
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic refused_r;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         refused_r <= 1'b0;
      end else begin
         refused_r <= refuse_deep;
      end
   end

   assign hrdata_o = rdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign gate_o.cpu_run = in_run;
   assign gate_o.high_speed_osc_on = hs_osc_on;
   assign gate_o.low_speed_osc_on = ls_osc_on;
   assign gate_o.substitute_clock_on = sub_on;
   assign gate_o.watchdog_clock_on = wdt_clk_on;
   assign gate_o.time_base_clock_on = !in_deepest_power_down_mode && !in_light_power_down_mode;
   assign gate_o.watchdog_disable = in_deepest_power_down_mode;
   assign system_clock_en_o = sys_en_r;
   assign system_clock_src_o = src_r;
   assign mode_o = state_r;
   assign deep_sleep_refused_o = refused_r;

endmodule // omcc_top

// File: verification/omcc_osc_model.sv
// Oscillator model that drives one clock waveform into the controller.
`timescale 1ns/100ps
module omcc_osc_model #(
   parameter int HALF = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   output logic osc_o
);
   int cnt;
   // A stopped oscillator rests low, so no stray rise can be counted.
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i || !en_i) begin
         cnt <= 0;
         osc_o <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         osc_o <= ~osc_o;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // omcc_osc_model

// File: verification/omcc_properties.sv
// Checker with the concurrent properties of the mode and clock controller.
`timescale 1ns/100ps
module omcc_properties
   import omcc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic high_speed_osc_i,
   input wire logic low_speed_osc_i,
   input wire omcc_pkg::omcc_cfg_t cfg_i,
   input wire logic halt_i,
   input wire logic wakeup_i,
   input wire omcc_pkg::omcc_gate_t gate_o,
   input wire logic system_clock_en_o,
   input wire logic [1:0] system_clock_src_o,
   input wire omcc_pkg::omcc_state_t mode_o,
   input wire logic deep_sleep_refused_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire st_run = (mode_o == OMCC_ST_RUN);
   wire st_i0 = (mode_o == OMCC_ST_IDLE_CLOCK_STOPPED_MODE);
   wire st_i1 = (mode_o == OMCC_ST_IDLE_CLOCK_KEPT_MODE);
   wire st_s0 = (mode_o == OMCC_ST_DEEPEST_POWER_DOWN_MODE);
   wire st_s1 = (mode_o == OMCC_ST_LIGHT_POWER_DOWN_MODE);
   wire on_sub = (system_clock_src_o == OMCC_SRC_SUB);
   wire halt_ok = st_run && halt_i && !on_sub;

   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer is not zero-wait OKAY");
   a_run_cpu: assert property (st_run |-> gate_o.cpu_run)
      else $error("CPU clock off in run mode");
   a_halt_leaves: assert property (
      halt_ok && !$past(st_i0 || st_s1) |=> !st_run)
      else $error("halt did not leave run mode");
   a_keep_idle: assert property (
      halt_ok && !$past(st_i0 || st_s1) &&
      cfg_i.system_clock_keep_in_idle |=> !st_i0)
      else $error("clock kept flag ignored at halt");
   a_deepest_power_down_mode_gates: assert property (st_s0 |-> !gate_o.cpu_run &&
      !gate_o.substitute_clock_on && !gate_o.watchdog_clock_on &&
      gate_o.watchdog_disable)
      else $error("deepest sleep left a clock running");
   a_deepest_power_down_mode_lvd: assert property (
      st_s0 && $past(st_run) |-> !$past(cfg_i.low_voltage_detector_enable))
      else $error("deepest sleep entered with detector on");
   a_refuse_pulse: assert property (deep_sleep_refused_o |->
      st_s1 && $past(halt_i && cfg_i.low_voltage_detector_enable))
      else $error("refusal pulse without its cause");
   a_light_power_down_mode_keep: assert property (st_s1 &&
      (cfg_i.low_voltage_detector_enable ||
      (cfg_i.watchdog_enable && cfg_i.watchdog_from_sub)) |->
      gate_o.substitute_clock_on && gate_o.watchdog_clock_on)
      else $error("light sleep stopped a needed clock");
   a_idle_clock_stopped_mode_still: assert property (st_i0 [*3] |-> !system_clock_en_o)
      else $error("system clock ticks in stopped idle");
   a_idle_clock_stopped_mode_wdog: assert property (st_i0 |->
      gate_o.watchdog_clock_on == cfg_i.watchdog_from_sub)
      else $error("watchdog clock wrong in stopped idle");
   a_idle_clock_kept_mode_wdog: assert property (st_i1 |->
      gate_o.watchdog_clock_on && !gate_o.cpu_run)
      else $error("watchdog clock off in kept idle");
   a_slow_hs_off: assert property (
      st_run && system_clock_src_o == OMCC_SRC_LOW |->
      !$past(gate_o.high_speed_osc_on))
      else $error("high-speed oscillator on in slow run");
   a_fast_run: assert property (on_sub |-> st_run)
      else $error("substitute clock outside run mode");

   c_deepest_power_down_mode: cover property (st_s0);
   c_idle_clock_kept_mode: cover property (st_i1);
   c_fast: cover property (on_sub);
   c_refused: cover property (deep_sleep_refused_o);
endmodule // omcc_properties

bind omcc_top omcc_properties u_omcc_properties (.sys_clk_i, .rst_b_i,
   .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
   .hrdata_o, .hreadyout_o, .hresp_o, .high_speed_osc_i, .low_speed_osc_i,
   .cfg_i, .halt_i, .wakeup_i, .gate_o, .system_clock_en_o,
   .system_clock_src_o, .mode_o, .deep_sleep_refused_o);

// File: verification/test_operating_mode_clock_control.sv
// Self-checking testbench of the operating mode and clock controller.
`timescale 1ns/100ps
module test_operating_mode_clock_control;
   import omcc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   logic halt_i = 1'b0;
   logic wakeup_i = 1'b0;
   omcc_cfg_t cfg_i = '{hs_source: OMCC_HS_INT_RC, default: 1'b0};
   wire hready_i;
   wire [31:0] hrdata_o;
   wire hreadyout_o, hresp_o, high_speed_osc_i, low_speed_osc_i;
   wire system_clock_en_o, deep_sleep_refused_o;
   wire [1:0] system_clock_src_o;
   omcc_gate_t gate_o;
   omcc_state_t mode_o;
   logic [31:0] rdat;
   int n_fail = 0;
   int n_compared = 0;
   int k;
   int n;
   int e;

   always #20 sys_clk_i = ~sys_clk_i;
   // The single slave's ready is the bus ready.
   assign hready_i = hreadyout_o;

   omcc_top u_omcc_top (.sys_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
      .hresp_o, .high_speed_osc_i, .low_speed_osc_i, .cfg_i, .halt_i,
      .wakeup_i, .gate_o, .system_clock_en_o, .system_clock_src_o, .mode_o,
      .deep_sleep_refused_o);
   omcc_osc_model #(.HALF(2)) u_hs_osc (.sys_clk_i, .rst_b_i,
      .en_i(gate_o.high_speed_osc_on), .osc_o(high_speed_osc_i));
   omcc_osc_model #(.HALF(3)) u_ls_osc (.sys_clk_i, .rst_b_i,
      .en_i(gate_o.low_speed_osc_on || gate_o.substitute_clock_on),
      .osc_o(low_speed_osc_i));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Samples are taken mid-cycle, so they equal what the edge sees.
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      logic r;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      hsel_i <= 1'b1;
      do begin
         @(negedge sys_clk_i) r = hreadyout_o;
         @(posedge sys_clk_i);
      end while (r !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do begin
         @(negedge sys_clk_i) r = hreadyout_o;
         rd = hrdata_o;
         @(posedge sys_clk_i);
      end while (r !== 1'b1);
   endtask

   // Waits for run mode on the given source; the wait length lands in k.
   task automatic settle(input logic [1:0] s, input int lim);
      logic ok;
      k = 0;
      do begin
         @(negedge sys_clk_i) ok = mode_o === OMCC_ST_RUN;
         ok = ok && system_clock_src_o === s;
         k++;
         @(posedge sys_clk_i);
      end while (!ok && k < lim);
      chk({31'h0, k < lim}, 32'h1);
   endtask

   task automatic pulse(input logic h);
      if (h) halt_i <= 1'b1;
      else wakeup_i <= 1'b1;
      @(posedge sys_clk_i);
      halt_i <= 1'b0;
      wakeup_i <= 1'b0;
   endtask

   function automatic logic [31:0] exp_mode(input logic [3:0] c);
      if (c[0]) return c[1] ? 32'h04 : 32'h02;
      return (c[2] || c[3]) ? 32'h10 : 32'h08;
   endfunction

   task tally_and_finish;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'h2d7f65f4));
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
      chk(rdat, 32'h03);
      settle(OMCC_SRC_HIGH, 400);
      bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
      chk(rdat, 32'h0F);
      bus(1'b1, OMCC_ADDR_CTRL, 32'h13, rdat);
      bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
      chk(rdat, 32'h1F);
      bus(1'b1, 32'h8, 32'hFF, rdat);
      bus(1'b0, 32'h8, 32'h0, rdat);
      chk(rdat, 32'h0);
      bus(1'b0, OMCC_ADDR_STAT, 32'h0, rdat);
      chk(rdat, 32'h01);
      $display("register test done");
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, OMCC_ADDR_CTRL, {24'h0, 3'(c), 5'h00}, rdat);
         repeat (200) @(posedge sys_clk_i);
         bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
         chk(rdat, {24'h0, 3'(c), 2'b01, c >= 2, 2'b00});
         chk({30'h0, system_clock_src_o}, (c < 2) ? 32'h2 : 32'h1);
         n = 0;
         repeat (1024) begin
            @(negedge sys_clk_i) n += int'(system_clock_en_o === 1'b1);
            @(posedge sys_clk_i);
         end
         e = (c < 2) ? 1024 / 6 : 1024 / (4 << (8 - c));
         chk({31'h0, n >= e - 2 && n <= e + 2}, 32'h1);
      end
      $display("divider test done");
      for (int c = 0; c < 16; c++) begin
         cfg_i.system_clock_keep_in_idle <= c[1];
         cfg_i.watchdog_enable <= c[2];
         cfg_i.low_voltage_detector_enable <= c[3];
         cfg_i.watchdog_from_sub <= 1'($urandom);
         bus(1'b1, OMCC_ADDR_CTRL, {30'h0, c[0], 1'b1}, rdat);
         settle(OMCC_SRC_HIGH, 400);
         pulse(1'b1);
         @(negedge sys_clk_i);
         chk({26'h0, mode_o}, exp_mode(4'(c)));
         chk({31'h0, deep_sleep_refused_o}, {31'h0, !c[0] && c[3]});
         @(posedge sys_clk_i);
         bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
         if (exp_mode(4'(c)) == 32'h08) chk({30'h0, rdat[3:2]}, 32'h0);
         if (exp_mode(4'(c)) == 32'h02) chk({31'h0, rdat[2]}, 32'h0);
         pulse(1'b0);
         settle(OMCC_SRC_HIGH, 400);
      end
      $display("mode test done");
      cfg_i.hs_source <= OMCC_HS_CRYSTAL;
      cfg_i.system_clock_keep_in_idle <= 1'b0;
      bus(1'b1, OMCC_ADDR_CTRL, 32'h13, rdat);
      settle(OMCC_SRC_HIGH, 6000);
      pulse(1'b1);
      repeat (4) @(posedge sys_clk_i);
      pulse(1'b0);
      settle(OMCC_SRC_SUB, 100);
      settle(OMCC_SRC_HIGH, 6000);
      chk({31'h0, k > 4000}, 32'h1);
      bus(1'b0, OMCC_ADDR_CTRL, 32'h0, rdat);
      chk({31'h0, rdat[2]}, 32'h1);
      $display("fast wake test done");
      tally_and_finish();
   end
endmodule // test_operating_mode_clock_control
